// file: common/slsub_defines.vh
// Constants for the left-shift / subtract execute datapath.
// Assumes 24-bit decoded instruction words and 16 working registers.
`ifndef SLSUB_DEFINES_VH
`define SLSUB_DEFINES_VH

// ----------------------------------------------------------------
// Opcode values
// ----------------------------------------------------------------
`define OPC_SL_FILE     8'hD4
`define OPC_SL_WORK     8'hD0
`define OPC_SL_MULTI    8'hDD
`define OPC_SUB_FILE    8'hB5
`define OPC_SUB_TEN_BIT_LITERAL   8'hB1
`define OPC_SUB_FIVE_BIT_LITERAL    5'h0A
`define SEL_FOUR_BIT_LITERAL        3'h4
`define SEL_REGCNT      3'h0
`define SEL_FIVE_BIT_LITERAL        2'h3

// ----------------------------------------------------------------
// Instruction field positions
// ----------------------------------------------------------------
`define F_OPC           23:16
`define F_TOP5          23:19
`define F_LOWBIT        15
`define F_BYTE          14
`define F_DSEL          13
`define F_FADDR         12:0
`define F_DMODE         13:11
`define F_DREG          10:7
`define F_SMODE         6:4
`define F_SREG          3:0
`define F_BASE          14:11
`define F_K4            3:0
`define F_K10           13:4
`define F_LWN           3:0
`define F_SBASE         18:15
`define F_K5            4:0
`define F_SEL3          6:4
`define F_SEL2          6:5

// ----------------------------------------------------------------
// Addressing modes
// ----------------------------------------------------------------
`define AM_DIRECT       3'h0
`define AM_POSTDEC      3'h2
`define AM_POSTINC      3'h3
`define AM_PREDEC       3'h4
`define AM_PREINC       3'h5

// ----------------------------------------------------------------
// Status word bits and misc values
// ----------------------------------------------------------------
`define SR_C            0
`define SR_Z            1
`define SR_OV           2
`define SR_N            3
`define SR_DC           8
`define BYTE_MSB        7
`define WORD_MSB        15
`define NIB_CARRY       4
`define MAX_SHIFT       16'h000F
`define DEFAULT_WORK_REG_IDX        4'h0
`define STEP_BYTE       16'h0001
`define STEP_WORD       16'h0002

`endif

// file: core/sl_shift_unit.v
// Left shifter: single-bit and multi-bit forms with flag results.
// Assumes operands are stable registers; purely combinational.
`timescale 1ns/1ns
`include "slsub_defines.vh"

module sl_shift_unit (
   input  wire [15:0] a_in,
   input  wire [15:0] cnt_in,
   input  wire        byte_in,
   input  wire        single_in,
   output wire [15:0] res_out,
   output wire        c_out,
   output wire        n_out,
   output wire        z_out
);
   // ----------------------------------------------------------------
   // Shift
   // ----------------------------------------------------------------
   wire        too_far = cnt_in > `MAX_SHIFT;
   wire [15:0] multi   = too_far ? 16'h0000 : (a_in << cnt_in[3:0]);
   wire [15:0] one     = {a_in[14:0], 1'b0};
   wire        bmode   = byte_in & single_in;

   assign res_out = single_in ? one : multi;
   // Top bit out of the operand lands in carry
   assign c_out = byte_in ? a_in[`BYTE_MSB] : a_in[`WORD_MSB];
   assign n_out = bmode ? res_out[`BYTE_MSB] : res_out[`WORD_MSB];
   assign z_out = bmode ? (res_out[7:0] == 8'h00) : (res_out == 16'h0000);

endmodule

// file: core/sl_sub_unit.v
// Subtractor a - b with digit carry, overflow, zero, negative, carry.
// Assumes operands are stable registers; purely combinational.
`timescale 1ns/1ns
`include "slsub_defines.vh"

module sl_sub_unit (
   input  wire [15:0] a_in,
   input  wire [15:0] b_in,
   input  wire        byte_in,
   output wire [15:0] res_out,
   output wire        c_out,
   output wire        dc_out,
   output wire        n_out,
   output wire        ov_out,
   output wire        z_out
);
   // ----------------------------------------------------------------
   // Arithmetic
   // ----------------------------------------------------------------
   wire [16:0] dw = {1'b0, a_in} - {1'b0, b_in};
   wire [8:0]  db = {1'b0, a_in[7:0]} - {1'b0, b_in[7:0]};
   wire [4:0]  dn = {1'b0, a_in[3:0]} - {1'b0, b_in[3:0]};
   wire        sa = byte_in ? a_in[`BYTE_MSB] : a_in[`WORD_MSB];
   wire        sb = byte_in ? b_in[`BYTE_MSB] : b_in[`WORD_MSB];

   assign res_out = dw[15:0];
   // Carry means no borrow; byte mode looks at low byte only
   assign c_out  = byte_in ? ~db[8] : ~dw[16];
   assign dc_out = ~dn[`NIB_CARRY];
   assign n_out  = byte_in ? dw[`BYTE_MSB] : dw[`WORD_MSB];
   assign ov_out = (sa ^ sb) & (sa ^ n_out);
   assign z_out  = byte_in ? (dw[7:0] == 8'h00) : (dw[15:0] == 16'h0000);

endmodule

// file: core/shift_left_subtract_execute.v
// Execute stage for the left-shift and subtract instruction group.
// Assumes a register file with combinational reads on two ports and
// one write port, and a data memory that answers with an ack pulse.
//
// What this block does
// - Decode working-register single shift, opcode D0
// - Decode literal-count shift, opcode DD, select 100
// - Decode register-count shift, opcode DD, select 000
// - Decode ten-bit literal subtract, opcode B1
// - Decode five-bit literal subtract, leading 01010
// - Byte bit: 0 word, 1 byte
// - Ten-bit literal subtract writes back into same register
// - Ten-bit literal subtract target is register direct only
// - Count above fifteen gives zero result
// - Single shifts update negative, zero, carry
// - Multi shifts update negative and zero only
// - Memory register accesses may take extra cycles
`timescale 1ns/1ns
`include "slsub_defines.vh"

module shift_left_subtract_execute (
   input  wire        mclk_in,
   input  wire        sys_rst_in,
   input  wire [23:0] instr_in,
   input  wire        instr_valid_in,
   input  wire [15:0] rf_rdata_a_in,
   input  wire [15:0] rf_rdata_b_in,
   input  wire [15:0] mem_rdata_in,
   input  wire        mem_ack_in,
   input  wire [15:0] status_word_in,
   output reg         ready_out,
   output reg         done_out,
   output reg         bad_op_out,
   output reg  [3:0]  rf_raddr_a_out,
   output reg  [3:0]  rf_raddr_b_out,
   output reg         rf_we_out,
   output reg  [3:0]  rf_waddr_out,
   output reg  [15:0] rf_wdata_out,
   output reg         rf_wbyte_out,
   output reg  [15:0] mem_addr_out,
   output reg         mem_rd_out,
   output reg         mem_wr_out,
   output reg  [15:0] mem_wdata_out,
   output reg         mem_byte_out,
   output reg         status_we_out,
   output reg  [15:0] status_word_out
);
   // ----------------------------------------------------------------
   // States and operation kinds
   // ----------------------------------------------------------------
   localparam S_IDLE = 3'h0;
   localparam S_READ = 3'h1;
   localparam S_MRD  = 3'h2;
   localparam S_EXEC = 3'h3;
   localparam S_MWR  = 3'h4;
   localparam S_SPTR = 3'h5;
   localparam S_DPTR = 3'h6;

   localparam K_SLF  = 3'h0;
   localparam K_SLW  = 3'h1;
   localparam K_SLK  = 3'h2;
   localparam K_SLR  = 3'h3;
   localparam K_SUBF = 3'h4;
   localparam K_SUBL = 3'h5;
   localparam K_SUBS = 3'h6;
   localparam K_BAD  = 3'h7;

   reg  [2:0]  state_q;
   reg  [23:0] instr_q;
   reg  [2:0]  kind_q;
   reg         byte_q;
   reg  [15:0] opa_q;
   reg  [15:0] opb_q;
   reg         dst_mem_q;
   reg  [15:0] dst_addr_q;
   reg  [3:0]  dst_reg_q;
   reg         sptr_upd_q;
   reg  [15:0] sptr_new_q;
   reg         dptr_upd_q;
   reg  [15:0] dptr_new_q;

   // ----------------------------------------------------------------
   // Decode of the incoming word
   // ----------------------------------------------------------------
   reg  [2:0]  kind_d;
   always @* begin
      kind_d = K_BAD;
      if (instr_in[`F_OPC] == `OPC_SL_FILE && !instr_in[`F_LOWBIT])
         kind_d = K_SLF;
      else if (instr_in[`F_OPC] == `OPC_SL_WORK && !instr_in[`F_LOWBIT])
         kind_d = K_SLW;
      else if (instr_in[`F_OPC] == `OPC_SL_MULTI && !instr_in[`F_LOWBIT]
               && instr_in[`F_SEL3] == `SEL_FOUR_BIT_LITERAL)
         kind_d = K_SLK;
      else if (instr_in[`F_OPC] == `OPC_SL_MULTI && !instr_in[`F_LOWBIT]
               && instr_in[`F_SEL3] == `SEL_REGCNT)
         kind_d = K_SLR;
      else if (instr_in[`F_OPC] == `OPC_SUB_FILE && !instr_in[`F_LOWBIT])
         kind_d = K_SUBF;
      else if (instr_in[`F_OPC] == `OPC_SUB_TEN_BIT_LITERAL && !instr_in[`F_LOWBIT])
         kind_d = K_SUBL;
      else if (instr_in[`F_TOP5] == `OPC_SUB_FIVE_BIT_LITERAL
               && instr_in[`F_SEL2] == `SEL_FIVE_BIT_LITERAL)
         kind_d = K_SUBS;
   end

   // Register-file read ports for each form
   reg  [3:0]  ra_d;
   reg  [3:0]  rb_d;
   always @* begin
      ra_d = `DEFAULT_WORK_REG_IDX;
      rb_d = `DEFAULT_WORK_REG_IDX;
      case (kind_d)
         K_SLW: begin
            ra_d = instr_in[`F_SREG];
            rb_d = instr_in[`F_DREG];
         end
         K_SLK: ra_d = instr_in[`F_BASE];
         K_SLR: begin
            ra_d = instr_in[`F_BASE];
            rb_d = instr_in[`F_SREG];
         end
         K_SUBL: ra_d = instr_in[`F_LWN];
         K_SUBS: begin
            ra_d = instr_in[`F_SBASE];
            rb_d = instr_in[`F_DREG];
         end
         default: ra_d = `DEFAULT_WORK_REG_IDX;
      endcase
   end

   // ----------------------------------------------------------------
   // Pointer arithmetic for indirect modes
   // ----------------------------------------------------------------
   function [15:0] eff_addr;
      input [2:0]  mode;
      input [15:0] ptr;
      input [15:0] step;
      begin
         if (mode == `AM_PREDEC)
            eff_addr = ptr - step;
         else if (mode == `AM_PREINC)
            eff_addr = ptr + step;
         else
            eff_addr = ptr;
      end
   endfunction

   function [15:0] new_ptr;
      input [2:0]  mode;
      input [15:0] ptr;
      input [15:0] step;
      begin
         if (mode == `AM_PREDEC || mode == `AM_POSTDEC)
            new_ptr = ptr - step;
         else if (mode == `AM_PREINC || mode == `AM_POSTINC)
            new_ptr = ptr + step;
         else
            new_ptr = ptr;
      end
   endfunction

   wire        is_file  = (kind_q == K_SLF) || (kind_q == K_SUBF);
   wire        is_sub   = (kind_q == K_SUBF) || (kind_q == K_SUBL) ||
                          (kind_q == K_SUBS);
   wire        single   = (kind_q == K_SLF) || (kind_q == K_SLW);
   wire [2:0]  smode    = (kind_q == K_SLW) ? instr_q[`F_SMODE] : `AM_DIRECT;
   wire [2:0]  dmode    = (kind_q == K_SLW || kind_q == K_SUBS) ?
                          instr_q[`F_DMODE] : `AM_DIRECT;
   wire [15:0] step     = byte_q ? `STEP_BYTE : `STEP_WORD;
   wire        src_mem  = is_file || (smode != `AM_DIRECT);
   wire        s_upd    = (smode >= `AM_POSTDEC) && (smode <= `AM_PREINC);
   wire        d_upd    = (dmode >= `AM_POSTDEC) && (dmode <= `AM_PREINC);
   // Ten-bit literal is zero-extended, never sign-extended
   wire [15:0] ten_bit_literal    = {6'h00, instr_q[`F_K10]};

   // ----------------------------------------------------------------
   // Arithmetic units
   // ----------------------------------------------------------------
   wire [15:0] sh_res;
   wire        sh_c;
   wire        sh_n;
   wire        sh_z;
   wire [15:0] sb_res;
   wire        sb_c;
   wire        sb_dc;
   wire        sb_n;
   wire        sb_ov;
   wire        sb_z;

   sl_shift_unit u_shift (
      .a_in      (opa_q),
      .cnt_in    (opb_q),
      .byte_in   (byte_q),
      .single_in (single),
      .res_out   (sh_res),
      .c_out     (sh_c),
      .n_out     (sh_n),
      .z_out     (sh_z)
   );

   sl_sub_unit u_sub (
      .a_in    (opa_q),
      .b_in    (opb_q),
      .byte_in (byte_q),
      .res_out (sb_res),
      .c_out   (sb_c),
      .dc_out  (sb_dc),
      .n_out   (sb_n),
      .ov_out  (sb_ov),
      .z_out   (sb_z)
   );

   // Status merge: untouched bits pass through from the core
   reg  [15:0] sr_d;
   always @* begin
      sr_d = status_word_in;
      if (is_sub) begin
         sr_d[`SR_C]  = sb_c;
         sr_d[`SR_Z]  = sb_z;
         sr_d[`SR_OV] = sb_ov;
         sr_d[`SR_N]  = sb_n;
         sr_d[`SR_DC] = sb_dc;
      end else if (single) begin
         sr_d[`SR_C]  = sh_c;
         sr_d[`SR_Z]  = sh_z;
         sr_d[`SR_N]  = sh_n;
      end else begin
         sr_d[`SR_Z]  = sh_z;
         sr_d[`SR_N]  = sh_n;
      end
   end

   wire [15:0] result = is_sub ? sb_res : sh_res;
   wire [2:0]  after_wr = sptr_upd_q ? S_SPTR :
                          (dptr_upd_q ? S_DPTR : S_IDLE);

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always @(posedge mclk_in) begin
      if (sys_rst_in) begin
         state_q         <= S_IDLE;
         instr_q         <= 24'h000000;
         kind_q          <= K_BAD;
         byte_q          <= 1'b0;
         opa_q           <= 16'h0000;
         opb_q           <= 16'h0000;
         dst_mem_q       <= 1'b0;
         dst_addr_q      <= 16'h0000;
         dst_reg_q       <= 4'h0;
         sptr_upd_q      <= 1'b0;
         sptr_new_q      <= 16'h0000;
         dptr_upd_q      <= 1'b0;
         dptr_new_q      <= 16'h0000;
         ready_out       <= 1'b1;
         done_out        <= 1'b0;
         bad_op_out      <= 1'b0;
         rf_raddr_a_out  <= 4'h0;
         rf_raddr_b_out  <= 4'h0;
         rf_we_out       <= 1'b0;
         rf_waddr_out    <= 4'h0;
         rf_wdata_out    <= 16'h0000;
         rf_wbyte_out    <= 1'b0;
         mem_addr_out    <= 16'h0000;
         mem_rd_out      <= 1'b0;
         mem_wr_out      <= 1'b0;
         mem_wdata_out   <= 16'h0000;
         mem_byte_out    <= 1'b0;
         status_we_out   <= 1'b0;
         status_word_out <= 16'h0000;
      end else begin
         done_out      <= 1'b0;
         bad_op_out    <= 1'b0;
         rf_we_out     <= 1'b0;
         status_we_out <= 1'b0;
         case (state_q)
            S_IDLE: begin
               if (instr_valid_in) begin
                  if (kind_d == K_BAD) begin
                     bad_op_out <= 1'b1;
                     done_out   <= 1'b1;
                  end else begin
                     instr_q        <= instr_in;
                     kind_q         <= kind_d;
                     // Multi-bit shifts are word-only
                     byte_q         <= instr_in[`F_BYTE] &&
                                       kind_d != K_SLK &&
                                       kind_d != K_SLR;
                     rf_raddr_a_out <= ra_d;
                     rf_raddr_b_out <= rb_d;
                     ready_out      <= 1'b0;
                     state_q        <= S_READ;
                  end
               end
            end
            S_READ: begin
               opa_q <= rf_rdata_a_in;
               case (kind_q)
                  K_SUBF:  opb_q <= rf_rdata_a_in;
                  K_SLK:   opb_q <= {12'h000, instr_q[`F_K4]};
                  K_SLR:   opb_q <= rf_rdata_b_in;
                  K_SUBL:  opb_q <= ten_bit_literal;
                  K_SUBS:  opb_q <= {11'h000, instr_q[`F_K5]};
                  default: opb_q <= 16'h0000;
               endcase
               sptr_upd_q <= s_upd;
               sptr_new_q <= new_ptr(smode, rf_rdata_a_in, step);
               dptr_upd_q <= d_upd;
               dptr_new_q <= new_ptr(dmode, rf_rdata_b_in, step);
               if (is_file) begin
                  dst_mem_q  <= instr_q[`F_DSEL];
                  dst_addr_q <= {3'h0, instr_q[`F_FADDR]};
                  dst_reg_q  <= `DEFAULT_WORK_REG_IDX;
               end else if (kind_q == K_SUBL) begin
                  // Target is always the register itself
                  dst_mem_q  <= 1'b0;
                  dst_reg_q  <= instr_q[`F_LWN];
               end else begin
                  dst_mem_q  <= dmode != `AM_DIRECT;
                  dst_addr_q <= eff_addr(dmode, rf_rdata_b_in, step);
                  dst_reg_q  <= instr_q[`F_DREG];
               end
               if (src_mem) begin
                  mem_addr_out <= is_file ? {3'h0, instr_q[`F_FADDR]} :
                                  eff_addr(smode, rf_rdata_a_in, step);
                  mem_byte_out <= byte_q;
                  mem_rd_out   <= 1'b1;
                  state_q      <= S_MRD;
               end else begin
                  state_q      <= S_EXEC;
               end
            end
            S_MRD: begin
               // Slow special registers stretch this wait
               if (mem_ack_in) begin
                  mem_rd_out <= 1'b0;
                  opa_q      <= mem_rdata_in;
                  state_q    <= S_EXEC;
               end
            end
            S_EXEC: begin
               status_word_out <= sr_d;
               status_we_out   <= 1'b1;
               if (dst_mem_q) begin
                  mem_addr_out  <= dst_addr_q;
                  mem_wdata_out <= result;
                  mem_byte_out  <= byte_q;
                  mem_wr_out    <= 1'b1;
                  state_q       <= S_MWR;
               end else begin
                  rf_we_out    <= 1'b1;
                  rf_waddr_out <= dst_reg_q;
                  rf_wdata_out <= result;
                  rf_wbyte_out <= byte_q;
                  state_q      <= after_wr;
                  ready_out    <= after_wr == S_IDLE;
                  done_out     <= after_wr == S_IDLE;
               end
            end
            S_MWR: begin
               if (mem_ack_in) begin
                  mem_wr_out <= 1'b0;
                  state_q    <= after_wr;
                  ready_out  <= after_wr == S_IDLE;
                  done_out   <= after_wr == S_IDLE;
               end
            end
            S_SPTR: begin
               rf_we_out    <= 1'b1;
               rf_waddr_out <= instr_q[`F_SREG];
               rf_wdata_out <= sptr_new_q;
               rf_wbyte_out <= 1'b0;
               state_q      <= dptr_upd_q ? S_DPTR : S_IDLE;
               ready_out    <= !dptr_upd_q;
               done_out     <= !dptr_upd_q;
            end
            S_DPTR: begin
               rf_we_out    <= 1'b1;
               rf_waddr_out <= instr_q[`F_DREG];
               rf_wdata_out <= dptr_new_q;
               rf_wbyte_out <= 1'b0;
               state_q      <= S_IDLE;
               ready_out    <= 1'b1;
               done_out     <= 1'b1;
            end
            default: begin
               state_q   <= S_IDLE;
               ready_out <= 1'b1;
            end
         endcase
      end
   end

endmodule

// file: test/slsub_checker.sv
// Port-level checks for the shift-left / subtract execute stage.
// Assumes the core holds status_word_in steady while an op runs.
`timescale 1ns/1ns

module slsub_checker (
   input wire        mclk_in,
   input wire        sys_rst_in,
   input wire [23:0] instr_in,
   input wire        instr_valid_in,
   input wire [15:0] status_word_in,
   input wire        ready_out,
   input wire        bad_op_out,
   input wire        rf_we_out,
   input wire [3:0]  rf_waddr_out,
   input wire [15:0] rf_wdata_out,
   input wire        rf_wbyte_out,
   input wire        mem_rd_out,
   input wire        mem_wr_out,
   input wire        status_we_out,
   input wire [15:0] status_word_out
);
   // ------------------
   // Helpers
   // ------------------
   wire        take = instr_valid_in & ready_out;
   wire [7:0]  opc  = instr_in[23:16];
   wire [15:0] chg  = status_word_out ^ status_word_in;
   wire        zres = rf_wbyte_out ? rf_wdata_out[7:0] == 8'h00
                                   : rf_wdata_out == 16'h0000;
   wire        nres = rf_wbyte_out ? rf_wdata_out[7] : rf_wdata_out[15];
   reg  [7:0]  op_q;
   reg         dsel_q;
   wire        fop  = op_q == 8'hB5 || op_q == 8'hD4;

   always @(posedge mclk_in) begin
      if (sys_rst_in) begin
         op_q <= 8'h00;
         dsel_q <= 1'b0;
      end else if (take) begin
         op_q <= opc;
         dsel_q <= instr_in[13];
      end
   end

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);

   chk_dec_shift:
   assert property (take && !instr_in[15] && (opc == 8'hD0 || opc == 8'hD4
      || opc == 8'hDD && instr_in[5:4] == 2'h0) |=> !bad_op_out)
      else $error("shift word refused");
   chk_dec_sub:
   assert property (take && (((opc == 8'hB5 || opc == 8'hB1) && !instr_in[15])
      || (instr_in[23:19] == 5'h0A && instr_in[6:5] == 2'h3)) |=> !bad_op_out)
      else $error("subtract word refused");
   chk_lit_wback:
   assert property (take && opc == 8'hB1 && !instr_in[15] |-> ##3
      rf_we_out && rf_waddr_out == $past(instr_in[3:0], 3))
      else $error("literal subtract not written back");
   chk_lit_direct:
   assert property (take && opc == 8'hB1 |=> (!mem_rd_out && !mem_wr_out) [*3])
      else $error("literal subtract touched memory");
   chk_one_keep:
   assert property (status_we_out && (op_q == 8'hD0 || op_q == 8'hD4)
      |-> (chg & 16'hFFF4) == 16'h0000)
      else $error("single shift changed other flags");
   chk_multi_keep:
   assert property (status_we_out && op_q == 8'hDD |-> (chg & 16'hFFF5) == 16'h0000)
      else $error("multi shift changed carry");
   chk_sub_keep:
   assert property (status_we_out && (op_q == 8'hB1 || op_q == 8'hB5
      || op_q[7:3] == 5'h0A) |-> (chg & 16'hFEF0) == 16'h0000)
      else $error("subtract changed other flags");
   chk_nz_result:
   assert property (status_we_out && rf_we_out
      |-> status_word_out[1] == zres && status_word_out[3] == nres)
      else $error("zero or negative flag wrong");
   chk_dest_sel:
   assert property (status_we_out && fop |-> rf_we_out != dsel_q
      && (rf_we_out ? rf_waddr_out == 4'h0 : mem_wr_out))
      else $error("file form destination wrong");

   cov_bad: cover property (take ##1 bad_op_out);
   cov_mem: cover property (status_we_out && mem_wr_out);
   cov_lit: cover property (take && opc == 8'hB1);
endmodule

bind shift_left_subtract_execute slsub_checker u_slsub_checker (.*);

// file: test/slsub_core_model.sv
// Register file and data memory beside the execute stage.
// Assumes one memory access at a time; slow_in stretches the answer.
`timescale 1ns/1ns

module slsub_core_model (
   input  wire        mclk_in,
   input  wire        sys_rst_in,
   input  wire        slow_in,
   input  wire [3:0]  raddr_a_in,
   input  wire [3:0]  raddr_b_in,
   input  wire        we_in,
   input  wire [3:0]  waddr_in,
   input  wire [15:0] wdata_in,
   input  wire        wbyte_in,
   input  wire [15:0] addr_in,
   input  wire        rd_in,
   input  wire        wr_in,
   input  wire [15:0] mdata_in,
   input  wire        mbyte_in,
   output wire [15:0] rdata_a_out,
   output wire [15:0] rdata_b_out,
   output wire [15:0] mdata_out,
   output reg         ack_out = 1'b0
);
   logic [15:0] rf [0:15];
   logic [15:0] mem [0:255];
   logic [1:0]  wait_q = 2'h0;
   wire  [7:0]  idx = addr_in[8:1];

   initial for (int i = 0; i < 256; i++) mem[i] = 16'h0000;
   initial for (int i = 0; i < 16; i++) rf[i] = 16'h0000;
   assign rdata_a_out = rf[raddr_a_in];
   assign rdata_b_out = rf[raddr_b_in];
   // Junk off the ack cycle, so a late sample cannot pass by luck
   assign mdata_out = ack_out ? mem[idx] : ~mem[idx];

   always @(posedge mclk_in) begin
      ack_out <= 1'b0;
      if (sys_rst_in)
         wait_q <= 2'h0;
      else if ((rd_in | wr_in) && !ack_out) begin
         wait_q <= wait_q + 2'h1;
         if (wait_q >= (slow_in ? 2'h2 : 2'h0)) begin
            ack_out <= 1'b1;
            wait_q <= 2'h0;
         end
      end
      if (we_in && wbyte_in) rf[waddr_in][7:0] <= wdata_in[7:0];
      else if (we_in) rf[waddr_in] <= wdata_in;
      if (wr_in && ack_out && mbyte_in) mem[idx][7:0] <= mdata_in[7:0];
      else if (wr_in && ack_out) mem[idx] <= mdata_in;
   end
endmodule

// file: test/shift_left_subtract_execute_test.sv
// Self-checking bench for the shift-left / subtract execute stage.
// Assumes the core model serves the register file and data memory.
`timescale 1ns/1ns

module shift_left_subtract_execute_test;
   logic        mclk_in = 1'b0, sys_rst_in = 1'b1, instr_valid_in = 1'b0;
   logic        slow = 1'b0, bad_q = 1'b0;
   logic [23:0] instr_in = 24'h000000;
   logic [15:0] status_word_in = 16'h0000, st_q = 16'h0000;
   wire  [15:0] rf_rdata_a_in, rf_rdata_b_in, mem_rdata_in, rf_wdata_out;
   wire  [15:0] mem_addr_out, mem_wdata_out, status_word_out;
   wire  [3:0]  rf_raddr_a_out, rf_raddr_b_out, rf_waddr_out;
   wire         mem_ack_in, ready_out, done_out, bad_op_out, rf_we_out;
   wire         rf_wbyte_out, mem_rd_out, mem_wr_out, mem_byte_out;
   wire         status_we_out;
   integer      error_cnt = 0, checked = 0;

   always #10 mclk_in = ~mclk_in;
   always @(posedge mclk_in) if (status_we_out === 1'b1) st_q <= status_word_out;

   shift_left_subtract_execute u_shift_left_subtract_execute (.*);

   slsub_core_model u_slsub_core_model (
      .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .slow_in(slow),
      .raddr_a_in(rf_raddr_a_out), .raddr_b_in(rf_raddr_b_out),
      .we_in(rf_we_out), .waddr_in(rf_waddr_out), .wdata_in(rf_wdata_out),
      .wbyte_in(rf_wbyte_out), .addr_in(mem_addr_out), .rd_in(mem_rd_out),
      .wr_in(mem_wr_out), .mdata_in(mem_wdata_out), .mbyte_in(mem_byte_out),
      .rdata_a_out(rf_rdata_a_in), .rdata_b_out(rf_rdata_b_in),
      .mdata_out(mem_rdata_in), .ack_out(mem_ack_in));

   // ------------------
   // Tasks
   // ------------------
   task check(input logic [15:0] got, input logic [15:0] exp);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask

   task op(input logic [23:0] ins, input logic [15:0] sin);
      integer n;
      begin
         @(negedge mclk_in);
         instr_in = ins;
         status_word_in = sin;
         instr_valid_in = 1'b1;
         @(negedge mclk_in);
         instr_valid_in = 1'b0;
         for (n = 0; done_out !== 1'b1 && n < 50; n = n + 1) @(negedge mclk_in);
         if (n == 50) error_cnt = error_cnt + 1;
         bad_q = bad_op_out;
         // Let the final write pulses land before anyone looks
         @(negedge mclk_in);
         $display("op %h done", ins);
      end
   endtask

   task end_of_test;
      begin
         $display("checked %0d errors %0d", checked, error_cnt);
         if (error_cnt == 0 && checked > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask

   // Generous span: the whole sequence needs under a hundred cycles
   initial begin
      #40000;
      error_cnt = error_cnt + 1;
      end_of_test;
   end

   initial begin
      repeat (5) @(negedge mclk_in);
      sys_rst_in = 1'b0;
      u_slsub_core_model.rf[3] = 16'h78A9;
      u_slsub_core_model.rf[4] = 16'h1005;
      op(24'hD04203, 16'h0104);
      check(u_slsub_core_model.rf[4], 16'h1052);
      check(st_q, 16'h0105);
      u_slsub_core_model.rf[2] = 16'h78A9;
      op(24'hDD1144, 16'h0001);
      check(u_slsub_core_model.rf[2], 16'h8A90);
      check(st_q, 16'h0009);
      u_slsub_core_model.rf[4] = 16'hA409;
      u_slsub_core_model.rf[5] = 16'hFF01;
      op(24'hDD2305, 16'h0001);
      check(u_slsub_core_model.rf[6], 16'h0000);
      check(st_q, 16'h0003);
      u_slsub_core_model.rf[5] = 16'h000F;
      op(24'hDD2305, 16'h0001);
      check(u_slsub_core_model.rf[6], 16'h8000);
      u_slsub_core_model.rf[4] = 16'h6234;
      op(24'hB11084, 16'h0000);
      check(u_slsub_core_model.rf[4], 16'h612C);
      check(st_q, 16'h0001);
      u_slsub_core_model.rf[0] = 16'h7804;
      op(24'hB14230, 16'h0000);
      check(u_slsub_core_model.rf[0], 16'h78E1);
      check(st_q, 16'h0108);
      u_slsub_core_model.rf[4] = 16'h1782;
      u_slsub_core_model.rf[5] = 16'h7804;
      op(24'h5242F0, 16'h0000);
      check(u_slsub_core_model.rf[5], 16'h7872);
      check(st_q, 16'h0105);
      u_slsub_core_model.rf[0] = 16'h6234;
      u_slsub_core_model.mem[8'h02] = 16'h4523;
      op(24'hB50A04, 16'h0000);
      check(u_slsub_core_model.rf[0], 16'hE2EF);
      check(st_q, 16'h0008);
      slow = 1'b1;
      u_slsub_core_model.mem[8'h80] = 16'h800F;
      op(24'hD42900, 16'h0000);
      check(u_slsub_core_model.mem[8'h80], 16'h001E);
      check(st_q, 16'h0001);
      slow = 1'b0;
      u_slsub_core_model.mem[8'h80] = 16'h800F;
      u_slsub_core_model.rf[2] = 16'h0900;
      u_slsub_core_model.rf[12] = 16'h1002;
      op(24'hD00E32, 16'h0000);
      check(u_slsub_core_model.mem[8'h01], 16'h001E);
      check(u_slsub_core_model.rf[2], 16'h0902);
      op(24'hDD1124, 16'h0000);
      check({15'h0000, bad_q}, 16'h0001);
      end_of_test;
   end
endmodule
